/* File: flash_status_pkg.sv */
// Shared constants for the flash status reporting block and its controller.
// Assumes a single 50 MHz clock and synchronous active-low reset everywhere.
package flash_status_pkg;
    // ----------------------
    // Status word layout
    // ----------------------
    localparam int STATUS_WIDTH = 9;
    localparam int DEV_BIT = 0;           // device_or_bank_flag
    localparam int BANK_LO_BIT = 1;       // bank_select_low_flag
    localparam int BANK_HI_BIT = 2;       // bank_select_high_flag
    localparam int PROT_BIT = 3;          // protection_violation_flag
    localparam int PROG_BIT = 4;          // program_fault_flag
    localparam int ERASE_BIT = 5;         // erase_fault_flag
    localparam int READY_BIT = 7;         // ready_flag
    localparam int INIT_BIT = 8;          // supply_init_fault_flag
    localparam logic [8:0] STATUS_RESET = 9'h080;
    // ----------------------
    // Operation codes (erase and unprotect ones carry the low bit)
    // ----------------------
    typedef enum logic [3:0] {
        OP_BANK_PROGRAM = 4'h0,
        OP_BANK_ERASE = 4'h1,
        OP_BLOCK_PROTECT = 4'h2,
        OP_BLOCK_UNPROTECT = 4'h3,
        OP_DEVICE_PROTECT = 4'h4,
        OP_DEVICE_UNPROTECT = 4'h5,
        OP_NV_PROGRAM = 4'h6,
        OP_NV_ERASE = 4'h7,
        OP_CLEAR_STATUS = 4'h8,
        OP_INIT = 4'h9,
        OP_INVALID = 4'hF
    } op_type;
    // ----------------------
    // Controller register map (AXI4-Lite byte offsets)
    // ----------------------
    localparam logic [7:0] REG_COMMAND = 8'h00;
    localparam logic [7:0] REG_CTRL_STATUS = 8'h04;
    localparam logic [7:0] REG_FLASH_STATUS = 8'h08;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ----------------------
    // Timing
    // ----------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int OP_TIME_NS = 200;      // default internal operation time
    localparam int OP_CYCLES = (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

/* File: flash_status_if.sv */
// Link between the flash status logic and its host controller.
// Assumes both ends share aclk; the reset/protect pin resets the device.
`timescale 1ns/1ps
interface flash_status_if;
    // Command strobe with its payload
    logic cmd_valid;
    flash_status_pkg::op_type cmd_op;
    logic [1:0] cmd_bank;
    logic cmd_violation;                  // Protection would block this op
    logic cmd_fail;                       // Inject verify failure
    // Device pins
    logic reset_protect_pin_n;
    logic high_voltage_override_level;
    // Device answers
    logic [8:0] status;
    logic array_read_mode;
    logic device_protect;
    modport device (
        input cmd_valid, cmd_op, cmd_bank, cmd_violation, cmd_fail,
        input reset_protect_pin_n, high_voltage_override_level,
        output status, array_read_mode, device_protect
    );
    modport host (
        output cmd_valid, cmd_op, cmd_bank, cmd_violation, cmd_fail,
        output reset_protect_pin_n, high_voltage_override_level,
        input status, array_read_mode, device_protect
    );
endinterface

/* File: flash_status_code_logic.sv */
// Internal write sequencer status of the flash device.
// Assumes commands arrive as single-cycle strobes from the host end.
`timescale 1ns/1ps
// Summary of operation
// - Bank op busy: bank bits, device bit zero
// - Block protect/unprotect busy reports code one
// - Device protect 3, nonvolatile 5, init 7
// - Bank program failure sets program bit
// - Device-level protect failures set program bit
// - Bank erase failure sets erase bit
// - Device-level unprotect failures set erase bit
// - Ready codes 080h, 090h, 098h
// - Ready erase failure 0A0h or 0A8h
// - Invalid sequence sets both fault bits
// - Top bit flags missing initialisation
// - Fault bits 3 to 5 sticky until clear status; init fault bit held until reset
// - Host may repeat sequences without reset
// - Host may check only ready
// - Bank returns to array read afterwards
// - Host may raise override before final step
// - Device protect bit can be reset
// - Further write accepted after device protect
// - Bank bits zero while ready
// - Device bit zero while ready
module flash_status_code_logic #(
    parameter int OP_LEN = flash_status_pkg::OP_CYCLES
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Link to host
    flash_status_if.device link
);
    import flash_status_pkg::*;
    // Refuse a busy time that the 16-bit counter cannot hold
    if (OP_LEN < 1 || OP_LEN > 65535) begin : g_bad_len
        $error("OP_LEN must lie between 1 and 65535");
    end
    // ----------------------
    // State
    // ----------------------
    typedef enum logic [1:0] {
        ST_INIT = 2'b00,
        ST_READY = 2'b01,
        ST_BUSY = 2'b10
    } state_type;
    state_type state;                     // Sequencer state
    op_type cur_op;                       // Operation in flight
    logic [1:0] cur_bank;                 // Bank under sequencer control
    logic cur_fail;                       // Running op will fail
    logic [15:0] count;                   // Remaining busy cycles
    logic prog_fault;                     // Sticky program fault
    logic erase_fault;                    // Sticky erase fault
    logic prot_fault;                     // Sticky protection violation
    logic init_fault;                     // Powered without initialisation
    logic dev_prot;                       // Device protect bit
    logic rst_n;                          // Combined reset
    logic [8:0] next_status;              // Status word being built
    logic is_dev;                         // Current op is device level
    logic fail_prog;                      // Failure maps to program fault
    assign rst_n = aresetn & link.reset_protect_pin_n;
    // Device-level operations
    function automatic logic dev_level(input op_type op);
        return (op != OP_BANK_PROGRAM) && (op != OP_BANK_ERASE);
    endfunction
    // Failure class: program/protect versus erase/unprotect
    function automatic logic prog_class(input op_type op);
        return (op == OP_BANK_PROGRAM) || (op == OP_BLOCK_PROTECT)
            || (op == OP_DEVICE_PROTECT) || (op == OP_NV_PROGRAM);
    endfunction
    // Busy low-bit code for device-level ops
    function automatic logic [2:0] dev_code(input op_type op);
        case (op)
            OP_BLOCK_PROTECT, OP_BLOCK_UNPROTECT: return 3'h1;
            OP_DEVICE_PROTECT, OP_DEVICE_UNPROTECT: return 3'h3;
            OP_NV_PROGRAM, OP_NV_ERASE: return 3'h5;
            default: return 3'h7;
        endcase
    endfunction
    assign is_dev = dev_level(cur_op);
    assign fail_prog = prog_class(cur_op);
    // ----------------------
    // Sequencer
    // ----------------------
    // Accepts commands only when ready; repeats need no reset
    always_ff @(posedge aclk) begin
        if (!rst_n) begin
            state <= ST_INIT;
            cur_op <= OP_INIT;
            cur_bank <= 2'h0;
            cur_fail <= 1'b0;
            count <= 16'(OP_LEN);
        end else begin
            case (state)
                // Initialisation cycle after reset
                ST_INIT: begin
                    if (count <= 16'h0001) begin
                        state <= ST_READY;
                    end else begin
                        count <= count - 16'h0001;
                    end
                end
                // Take a new operation
                ST_READY: begin
                    if (link.cmd_valid && link.cmd_op != OP_CLEAR_STATUS
                        && link.cmd_op != OP_INVALID && link.cmd_op != OP_INIT
                        && !link.cmd_violation) begin
                        state <= ST_BUSY;
                        cur_op <= link.cmd_op;
                        cur_bank <= link.cmd_bank;
                        cur_fail <= link.cmd_fail;
                        count <= 16'(OP_LEN);
                    end
                end
                // Run out the operation, then back to ready
                ST_BUSY: begin
                    if (count <= 16'h0001) begin
                        state <= ST_READY;
                    end else begin
                        count <= count - 16'h0001;
                    end
                end
                default: state <= ST_INIT;
            endcase
        end
    end
    // ----------------------
    // Sticky faults
    // ----------------------
    // Set wins over clear status in the same cycle
    always_ff @(posedge aclk) begin
        if (!rst_n) begin
            prog_fault <= 1'b0;
            erase_fault <= 1'b0;
            prot_fault <= 1'b0;
        end else begin
            // Clear status only taken while ready
            if (link.cmd_valid && link.cmd_op == OP_CLEAR_STATUS
                && state == ST_READY) begin
                prog_fault <= 1'b0;
                erase_fault <= 1'b0;
                prot_fault <= 1'b0;
            end
            // Verify failure shows on the first busy cycle
            if (state == ST_BUSY && cur_fail && count == 16'(OP_LEN)) begin
                if (fail_prog) begin
                    prog_fault <= 1'b1;
                end else begin
                    erase_fault <= 1'b1;
                end
            end
            // Invalid sequence or blocked operation
            if (link.cmd_valid && state == ST_READY) begin
                if (link.cmd_op == OP_INVALID) begin
                    prog_fault <= 1'b1;
                    erase_fault <= 1'b1;
                    prot_fault <= link.cmd_violation | prot_fault;
                end else if (link.cmd_violation && link.cmd_op != OP_CLEAR_STATUS) begin
                    prot_fault <= 1'b1;
                    if (prog_class(link.cmd_op)) begin
                        prog_fault <= 1'b1;
                    end else begin
                        erase_fault <= 1'b1;
                    end
                end
            end
        end
    end
    // ----------------------
    // Init fault and device protect bit
    // ----------------------
    // Init fault raised by an init command with fail set during the init cycle after any reset
    always_ff @(posedge aclk) begin
        if (!rst_n) begin
            init_fault <= 1'b0;
            dev_prot <= 1'b0;
        end else begin
            if (state == ST_INIT && link.cmd_valid && link.cmd_op == OP_INIT
                && link.cmd_fail) begin
                init_fault <= 1'b1;
            end
            if (state == ST_BUSY && count <= 16'h0001 && !cur_fail) begin
                if (cur_op == OP_DEVICE_PROTECT) begin
                    dev_prot <= 1'b1;
                end else if (cur_op == OP_DEVICE_UNPROTECT) begin
                    dev_prot <= 1'b0;
                end
            end
        end
    end
    // ----------------------
    // Status word
    // ----------------------
    always_comb begin
        next_status = 9'h000;
        next_status[PROG_BIT] = prog_fault;
        next_status[ERASE_BIT] = erase_fault;
        if (state == ST_READY) begin
            next_status[READY_BIT] = 1'b1;
            next_status[PROT_BIT] = prot_fault;
            // Bank and device bits stay zero
        end else if (state == ST_INIT) begin
            next_status[2:0] = dev_code(OP_INIT);
        end else if (is_dev) begin
            next_status[2:0] = dev_code(cur_op);
        end else begin
            next_status[BANK_HI_BIT:BANK_LO_BIT] = cur_bank;
        end
        next_status[INIT_BIT] = init_fault;
    end
    // Registered outputs
    always_ff @(posedge aclk) begin
        if (!rst_n) begin
            link.status <= STATUS_RESET;
            link.array_read_mode <= 1'b1;
            link.device_protect <= 1'b0;
        end else begin
            link.status <= next_status;
            link.array_read_mode <= (state != ST_BUSY);
            link.device_protect <= dev_prot;
        end
    end
endmodule

/* File: flash_status_host.sv */
// Host controller issuing flash command sequences from AXI4-Lite.
// Assumes the device end shares aclk through the common interface.
`timescale 1ns/1ps
module flash_status_host (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Link to device
    flash_status_if.host link
);
    import flash_status_pkg::*;
    // ----------------------
    // Write channel
    // ----------------------
    logic aw_held;                        // Address taken
    logic w_held;                         // Data taken
    logic [7:0] aw_addr;                  // Held address
    logic [31:0] w_data;                  // Held data
    logic [3:0] w_strb;                   // Held strobes
    logic pins_n;                         // Reset/protect pin level
    logic hv;                             // Override level
    // Command word: [3:0] op, [5:4] bank, [6] violation, [7] fail
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            link.cmd_valid <= 1'b0;
            link.cmd_op <= OP_CLEAR_STATUS;
            link.cmd_bank <= 2'h0;
            link.cmd_violation <= 1'b0;
            link.cmd_fail <= 1'b0;
            pins_n <= 1'b1;
            hv <= 1'b0;
        end else begin
            link.cmd_valid <= 1'b0;
            s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !w_held && !s_axi_wready && !s_axi_bvalid;
            // Capture address and data in either order
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            // Both held: act and respond
            if (aw_held && w_held && !s_axi_bvalid) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= RESP_OKAY;
                if (aw_addr == REG_COMMAND) begin
                    if (w_strb[0]) begin
                        link.cmd_valid <= 1'b1;
                        link.cmd_op <= op_type'(w_data[3:0]);
                        link.cmd_bank <= w_data[5:4];
                        link.cmd_violation <= w_data[6];
                        link.cmd_fail <= w_data[7];
                    end
                end else if (aw_addr == REG_CTRL_STATUS) begin
                    if (w_strb[0]) begin
                        pins_n <= !w_data[0];
                        hv <= w_data[1];
                    end
                end else if (aw_addr != REG_FLASH_STATUS) begin
                    s_axi_bresp <= RESP_SLVERR;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    assign link.reset_protect_pin_n = pins_n;
    assign link.high_voltage_override_level = hv;
    // ----------------------
    // Read channel
    // ----------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= RESP_OKAY;
                if (s_axi_araddr == REG_FLASH_STATUS) begin
                    s_axi_rdata <= {23'h000000, link.status};
                end else if (s_axi_araddr == REG_CTRL_STATUS) begin
                    s_axi_rdata <= {28'h0000000, link.device_protect,
                        link.array_read_mode, hv, !pins_n};
                end else if (s_axi_araddr == REG_COMMAND) begin
                    s_axi_rdata <= 32'h00000000;
                end else begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

/* File: flash_status_monitor.sv */
// Assertions on the link between the flash status device and its host.
// Assumes it sits beside the link interface, on the same clock and reset.
`timescale 1ns/1ps
module flash_status_monitor (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Commands from the host
    input wire logic cmd_valid,
    input var flash_status_pkg::op_type cmd_op,
    input wire logic [1:0] cmd_bank,
    input wire logic cmd_violation,
    input wire logic cmd_fail,
    input wire logic reset_protect_pin_n,
    // Device answers
    input wire logic [8:0] status,
    input wire logic array_read_mode
);
    import flash_status_pkg::*;
    // ----------------------
    // Expectations captured at each command
    // ----------------------
    logic take;           // Command meets a clean ready device
    logic [8:0] exp_busy; // Busy code owed
    logic [8:0] exp_end;  // Ready code owed after a fault
    assign take = cmd_valid && status == STATUS_RESET && !cmd_op[3];
    // Device-level op pairs give 1, 3, 5; bank ops show their bank
    always_ff @(posedge aclk) begin
        if (cmd_valid) begin
            exp_busy <= (cmd_op[2:1] == 2'h0) ? {6'h00, cmd_bank, 1'b0}
                                             : {6'h00, cmd_op[2:1] - 2'h1, 1'b1};
            exp_end <= {3'h2, cmd_op[3] | cmd_op[0], cmd_op[3] | !cmd_op[0], cmd_violation, 3'h0};
        end
    end
    // ----------------------
    // Assertions
    // ----------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn || !reset_protect_pin_n);
    AST_BANK_BUSY: assert property (
        take && !cmd_fail && !cmd_violation && cmd_op[2:1] == 2'h0 |-> ##[1:3] status == exp_busy)
        else $error("bank busy code wrong");
    AST_DEVICE_BUSY: assert property (
        take && !cmd_fail && !cmd_violation && cmd_op[2:1] != 2'h0 |-> ##[1:3] status == exp_busy)
        else $error("device-level busy code wrong");
    AST_PROG_FAULT: assert property (
        take && cmd_fail && !cmd_violation && !cmd_op[0]
        |-> ##[1:4] status == (exp_busy | 9'h010) ##[1:40] status == exp_end)
        else $error("program fault codes wrong");
    AST_ERASE_FAULT: assert property (
        take && cmd_fail && !cmd_violation && cmd_op[0]
        |-> ##[1:4] status == (exp_busy | 9'h020) ##[1:40] status == exp_end)
        else $error("erase fault codes wrong");
    AST_VIOLATION: assert property (
        take && cmd_violation |-> ##[1:3] status == exp_end)
        else $error("protection violation code wrong");
    AST_INVALID: assert property (
        cmd_valid && cmd_op == OP_INVALID && status == STATUS_RESET |-> ##[1:3] status == exp_end)
        else $error("command sequence error code wrong");
    AST_READY_LOW: assert property (
        status[7] && !status[8] |-> status[2:0] == 3'h0)
        else $error("low bits set while ready");
    AST_STICKY: assert property (
        status[7] && !status[8] && !cmd_valid && !$past(cmd_valid)
        |=> (status[5:3] & $past(status[5:3])) == $past(status[5:3]))
        else $error("fault bit dropped without clear");
    AST_CLEAR: assert property (
        cmd_valid && cmd_op == OP_CLEAR_STATUS && status[7] && !status[8]
        |-> ##[1:3] status[5:3] == 3'h0)
        else $error("clear left fault bits");
    AST_INIT_FAULT: assert property (
        cmd_valid && cmd_op == OP_INIT && cmd_fail && status == 9'h007 |-> ##[1:20] status[8])
        else $error("init fault not flagged");
    AST_ARRAY_READ: assert property (
        $rose(status[7]) |=> array_read_mode)
        else $error("no array read after operation");
    // Main scenarios reached
    cover property (take && cmd_fail);
    cover property (take && cmd_violation);
    cover property (status[8]);
endmodule

/* File: flash_status_code_logic_tb.sv */
// Self-checking bench: AXI4-Lite writes and reads drive host and device.
// Assumes both ends meet in the link interface on one 50 MHz clock.
`timescale 1ns/1ps
module flash_status_code_logic_tb;
    import flash_status_pkg::*;
    // ----------------------
    // Signals and instances
    // ----------------------
    localparam int OP_LEN = 12; // Long enough for a command to land during init
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int num_errors = 0;
    int checks_done = 0;
    logic dp = 1'b0; // Expected device protect state
    always #10 aclk = ~aclk;
    flash_status_if u_flash_status_if ();
    flash_status_code_logic #(.OP_LEN(OP_LEN)) u_flash_status_code_logic (
        .aclk(aclk), .aresetn(aresetn), .link(u_flash_status_if.device));
    flash_status_host u_flash_status_host (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .link(u_flash_status_if.host));
    flash_status_monitor u_flash_status_monitor (.aclk(aclk), .aresetn(aresetn),
        .cmd_valid(u_flash_status_if.cmd_valid), .cmd_op(u_flash_status_if.cmd_op),
        .cmd_bank(u_flash_status_if.cmd_bank), .cmd_violation(u_flash_status_if.cmd_violation),
        .cmd_fail(u_flash_status_if.cmd_fail), .status(u_flash_status_if.status),
        .reset_protect_pin_n(u_flash_status_if.reset_protect_pin_n),
        .array_read_mode(u_flash_status_if.array_read_mode));
    // ----------------------
    // Reporting
    // ----------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
            num_errors++;
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // ----------------------
    // Bus tasks
    // ----------------------
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (n > 50) check(32'h0, 32'h1, "write timeout");
            if (n > 50) end_sim();
        end while (!(s_axi_bvalid && s_axi_bready));
        check({30'h0, s_axi_bresp}, (a > REG_FLASH_STATUS) ? {30'h0, RESP_SLVERR} : 32'h0,
            "write response");
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (n > 50) check(32'h0, 32'h1, "read timeout");
            if (n > 50) end_sim();
        end while (!(s_axi_rvalid && s_axi_rready));
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // Poll status until the masked match equals want
    task automatic poll(input logic [8:0] mask, input logic [8:0] val, input bit want,
                        output logic [31:0] s);
        logic [1:0] r;
        for (int i = 0; i < 200; i++) begin
            axi_read(REG_FLASH_STATUS, s, r);
            if (((s[8:0] & mask) === val) == want) return;
        end
        check(32'h0, 32'h1, "status wait timeout");
        end_sim();
    endtask
    task automatic clear_status();
        logic [31:0] s;
        axi_write(REG_COMMAND, 32'h8);
        poll(9'h1FF, 9'h080, 1'b1, s);
        check({23'h0, s[8:0]}, 32'h80, "after clear");
    endtask
    // One operation: m 0 clean, 1 verify failure, 2 protection violation
    task automatic run_op(input int o, input int b, input int m);
        logic [31:0] s;
        logic [1:0] r;
        logic [8:0] e;
        e = (m == 0) ? 9'h080 : {3'h2, o[0], ~o[0], m == 2, 3'h0};
        axi_write(REG_COMMAND, {24'h0, m == 1, m == 2, b[1:0], o[3:0]});
        if (m < 2) poll(9'h080, 9'h000, 1'b1, s);
        else poll(9'h1FF, 9'h080, 1'b0, s);
        if (m == 0) check({23'h0, s[8:0]}, (o < 2) ? {b[1:0], 1'b0} : (o < 4) ? 32'h1
            : (o < 6) ? 32'h3 : 32'h5, "busy");
        poll(9'h080, 9'h080, 1'b1, s);
        check({23'h0, s[8:0]}, {23'h0, e}, "ready");
        if (m > 0) begin
            axi_read(REG_FLASH_STATUS, s, r);
            check({23'h0, s[8:0]}, {23'h0, e}, "sticky");
            clear_status();
        end
        if (m == 0 && o == 4) dp = 1'b1;
        if (m == 0 && o == 5) dp = 1'b0;
        axi_read(REG_CTRL_STATUS, s, r);
        check(s, {28'h0, dp, 3'h6}, "ctrl");
    endtask
    // ----------------------
    // Test sequence
    // ----------------------
    initial begin
        logic [31:0] s;
        logic [1:0] r;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        poll(9'h080, 9'h000, 1'b1, s);
        check({23'h0, s[8:0]}, 32'h7, "init busy");
        poll(9'h1FF, 9'h080, 1'b1, s);
        check({23'h0, s[8:0]}, 32'h80, "ready");
        axi_read(8'h0C, s, r);
        check({s[29:0], r}, {30'h0, RESP_SLVERR}, "unmapped");
        axi_write(8'h0C, 32'h0);
        $display("test reset done");
        axi_write(REG_CTRL_STATUS, 32'h2);
        for (int o = 0; o < 8; o++) begin
            for (int b = 0; b < 4; b++) begin
                for (int m = 0; m < 3; m++) begin
                    if (o < 2 || b == 0) run_op(o, b, m);
                end
            end
        end
        $display("test operations done");
        for (int v = 0; v < 2; v++) begin
            axi_write(REG_COMMAND, {24'h0, 1'b0, v[0], 2'h0, 4'hF});
            poll(9'h1FF, 9'h080, 1'b0, s);
            check({23'h0, s[8:0]}, v ? 32'hB8 : 32'hB0, "sequence error");
            clear_status();
        end
        $display("test invalid done");
        axi_write(REG_CTRL_STATUS, 32'h1);
        axi_write(REG_CTRL_STATUS, 32'h0);
        axi_write(REG_COMMAND, 32'h89);
        poll(9'h100, 9'h100, 1'b1, s);
        check({31'h0, s[8]}, 32'h1, "init fault");
        axi_write(REG_CTRL_STATUS, 32'h1);
        axi_write(REG_CTRL_STATUS, 32'h0);
        clear_status();
        $display("test init fault done");
        end_sim();
    end
endmodule
